// [verilog/cfg_status_pkg.sv]
package cfg_status_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam logic [6:0] ADDR_GLOBAL_CONFIG = 7'h00;
	localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
	localparam logic [6:0] ADDR_UART_WRITE_COUNTER = 7'h02;
	localparam logic [6:0] ADDR_TARGET_POSITION = 7'h2d;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_DIAG_A_DRIVE_BIT = 12;
	localparam int CFG_DIAG_B_DRIVE_BIT = 13;
	localparam int CFG_SMALL_HYST_BIT = 14;
	localparam int CFG_STOP_ENABLE_BIT = 15;
	localparam int CFG_DIRECT_MODE_BIT = 16;
	localparam int CFG_TEST_MODE_BIT = 17;
	localparam int STAT_RESET_BIT = 0;
	localparam int STAT_DRV_ERR_BIT = 1;
	localparam int STAT_PUMP_UV_BIT = 2;
	localparam int STAT_W = 3;
	localparam int COUNT_W = 8;
	localparam int COIL_W = 9;
	localparam int COIL_A_LSB = 0;
	localparam int COIL_B_LSB = 16;
	localparam int HOLD_W = 5;
	localparam int FREQ_W = 20;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] STATUS_RESET = 3'h1;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [2:0] HYST_SHIFT_WIDE = 3'h4;
	localparam logic [2:0] HYST_SHIFT_SMALL = 3'h5;
	localparam int HOLD_SCALE_SHIFT = 5;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic diag_a_drive_select;
		logic diag_b_drive_select;
		logic small_hysteresis;
		logic stop_enable;
		logic direct_mode;
		logic test_mode;
	} cfg_t;

	typedef struct packed {
		logic signed [8:0] coil_a;
		logic signed [8:0] coil_b;
	} coil_t;

	typedef struct packed {
		logic value;
		logic enable;
	} pin_drive_t;

endpackage

// [verilog/global_config_status_bank.sv]
`timescale 1ns/100ps
`default_nettype none

module global_config_status_bank (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire cfg_status_pkg::reg_req_t reg_req_in,
	input wire logic uart_mode_in,
	input wire logic write_ok_in,
	input wire logic halt_request_input_in,
	input wire logic pump_undervoltage_in,
	input wire logic drv_shutdown_in,
	input wire logic over_temp_in,
	input wire logic diag_a_event_in,
	input wire logic diag_b_event_in,
	input wire logic [cfg_status_pkg::HOLD_W-1:0] hold_current_setting_in,
	input wire logic [cfg_status_pkg::FREQ_W-1:0] freq_threshold_in,
	output logic [cfg_status_pkg::DATA_W-1:0] reg_rdata_out,
	output cfg_status_pkg::pin_drive_t diag_a_pin_out,
	output cfg_status_pkg::pin_drive_t diag_b_pin_out,
	output logic [cfg_status_pkg::FREQ_W-1:0] hyst_amount_out,
	output logic step_enable_out,
	output logic standstill_out,
	output logic driver_enable_out,
	output logic direct_mode_out,
	output logic quiet_velocity_reg_enable_out,
	output cfg_status_pkg::coil_t coil_current_out,
	output logic test_out_enable_out,
	output logic [1:0] test_select_out
);
	import cfg_status_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_STAGES-1:0] halt_sync_q;
	logic [SYNC_STAGES-1:0] uv_sync_q;
	logic halt_s;
	logic uv_s;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			halt_sync_q <= '0;
			uv_sync_q <= '0;
		end else begin
			halt_sync_q <= {halt_sync_q[0], halt_request_input_in};
			uv_sync_q <= {uv_sync_q[0], pump_undervoltage_in};
		end
	end

	assign halt_s = halt_sync_q[SYNC_STAGES-1];
	assign uv_s = uv_sync_q[SYNC_STAGES-1];

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	cfg_t cfg_q, cfg_d;
	logic [STAT_W-1:0] stat_q, stat_d;
	logic [COUNT_W-1:0] count_q, count_d;
	coil_t target_q, target_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic wr_cfg, wr_stat, wr_target;
	logic [STAT_W-1:0] stat_set, stat_clr;

	function automatic logic hit(input reg_req_t req, input logic [6:0] addr);
		hit = req.wr && (req.addr == addr);
	endfunction

	always_comb begin
		wr_cfg = hit(reg_req_in, ADDR_GLOBAL_CONFIG);
		wr_stat = hit(reg_req_in, ADDR_GLOBAL_STATUS);
		wr_target = hit(reg_req_in, ADDR_TARGET_POSITION);
		cfg_d = cfg_q;
		if (wr_cfg) begin
			cfg_d.diag_a_drive_select = reg_req_in.wdata[CFG_DIAG_A_DRIVE_BIT];
			cfg_d.diag_b_drive_select = reg_req_in.wdata[CFG_DIAG_B_DRIVE_BIT];
			cfg_d.small_hysteresis = reg_req_in.wdata[CFG_SMALL_HYST_BIT];
			cfg_d.stop_enable = reg_req_in.wdata[CFG_STOP_ENABLE_BIT];
			cfg_d.direct_mode = reg_req_in.wdata[CFG_DIRECT_MODE_BIT];
			cfg_d.test_mode = reg_req_in.wdata[CFG_TEST_MODE_BIT];
		end
		target_d = target_q;
		if (wr_target) begin
			target_d.coil_a = reg_req_in.wdata[COIL_A_LSB +: COIL_W];
			target_d.coil_b = reg_req_in.wdata[COIL_B_LSB +: COIL_W];
		end
		stat_set = '0;
		stat_set[STAT_DRV_ERR_BIT] = drv_shutdown_in;
		stat_set[STAT_PUMP_UV_BIT] = uv_s;
		stat_clr = wr_stat ? reg_req_in.wdata[STAT_W-1:0] : '0;
		stat_clr[STAT_DRV_ERR_BIT] = stat_clr[STAT_DRV_ERR_BIT] & ~over_temp_in;
		stat_d = (stat_q & ~stat_clr) | stat_set;
		count_d = count_q;
		if (reg_req_in.wr && uart_mode_in && write_ok_in) begin
			count_d = count_q + 8'h01;
		end
		rdata_d = rdata_q;
		if (reg_req_in.rd) begin
			rdata_d = '0;
			unique case (reg_req_in.addr)
				ADDR_GLOBAL_CONFIG: begin
					rdata_d[CFG_DIAG_A_DRIVE_BIT] = cfg_q.diag_a_drive_select;
					rdata_d[CFG_DIAG_B_DRIVE_BIT] = cfg_q.diag_b_drive_select;
					rdata_d[CFG_SMALL_HYST_BIT] = cfg_q.small_hysteresis;
					rdata_d[CFG_STOP_ENABLE_BIT] = cfg_q.stop_enable;
					rdata_d[CFG_DIRECT_MODE_BIT] = cfg_q.direct_mode;
					rdata_d[CFG_TEST_MODE_BIT] = cfg_q.test_mode;
				end
				ADDR_GLOBAL_STATUS: rdata_d[STAT_W-1:0] = stat_q;
				ADDR_UART_WRITE_COUNTER: rdata_d[COUNT_W-1:0] = count_q;
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_q <= '0;
			stat_q <= STATUS_RESET;
			count_q <= COUNT_RESET;
			target_q <= '0;
			rdata_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			stat_q <= stat_d;
			count_q <= count_d;
			target_q <= target_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Pins and control outputs
	// ----------------------------------------------------------------
	pin_drive_t diag_a_q, diag_a_d, diag_b_q, diag_b_d;
	logic [FREQ_W-1:0] hyst_q, hyst_d;
	logic step_en_q, step_en_d;
	logic drv_en_q, drv_en_d;
	coil_t coil_q, coil_d;
	logic test_en_q, test_en_d;
	logic [1:0] test_sel_q, test_sel_d;
	logic signed [COIL_W+HOLD_W+1:0] prod_a, prod_b;

	always_comb begin
		diag_a_d.value = cfg_q.diag_a_drive_select ? diag_a_event_in : 1'b0;
		diag_a_d.enable = cfg_q.diag_a_drive_select ? 1'b1 : diag_a_event_in;
		diag_b_d.value = cfg_q.diag_b_drive_select ? diag_b_event_in : 1'b0;
		diag_b_d.enable = cfg_q.diag_b_drive_select ? 1'b1 : diag_b_event_in;
		hyst_d = freq_threshold_in >> (cfg_q.small_hysteresis ? HYST_SHIFT_SMALL
			: HYST_SHIFT_WIDE);
		step_en_d = ~(cfg_q.stop_enable & halt_s);
		drv_en_d = ~uv_s & ~stat_q[STAT_DRV_ERR_BIT];
		prod_a = target_q.coil_a * $signed({1'b0, hold_current_setting_in} + 7'sh01);
		prod_b = target_q.coil_b * $signed({1'b0, hold_current_setting_in} + 7'sh01);
		coil_d.coil_a = cfg_q.direct_mode ? prod_a[HOLD_SCALE_SHIFT +: COIL_W] : '0;
		coil_d.coil_b = cfg_q.direct_mode ? prod_b[HOLD_SCALE_SHIFT +: COIL_W] : '0;
		test_en_d = cfg_q.test_mode;
		test_sel_d = cfg_q.test_mode ? hold_current_setting_in[1:0] : 2'h0;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			diag_a_q <= 2'h1;
			diag_b_q <= 2'h0;
			hyst_q <= '0;
			step_en_q <= 1'b1;
			drv_en_q <= 1'b0;
			coil_q <= '0;
			test_en_q <= 1'b0;
			test_sel_q <= 2'h0;
		end else begin
			diag_a_q <= diag_a_d;
			diag_b_q <= diag_b_d;
			hyst_q <= hyst_d;
			step_en_q <= step_en_d;
			drv_en_q <= drv_en_d;
			coil_q <= coil_d;
			test_en_q <= test_en_d;
			test_sel_q <= test_sel_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign diag_a_pin_out = diag_a_q;
	assign diag_b_pin_out = diag_b_q;
	assign hyst_amount_out = hyst_q;
	assign step_enable_out = step_en_q;
	assign standstill_out = ~step_en_q;
	assign driver_enable_out = drv_en_q;
	assign direct_mode_out = cfg_q.direct_mode;
	assign quiet_velocity_reg_enable_out = ~cfg_q.direct_mode;
	assign coil_current_out = coil_q;
	assign test_out_enable_out = test_en_q;
	assign test_select_out = test_sel_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_set_wins: assert property (drv_shutdown_in |=> stat_q[STAT_DRV_ERR_BIT])
		else $error("Driver error set lost against clear.");
	chk_w1c_clear: assert property (wr_stat && reg_req_in.wdata[STAT_RESET_BIT]
		|=> !stat_q[STAT_RESET_BIT])
		else $error("Reset flag not cleared by write one.");
	chk_w0_keeps: assert property (wr_stat && !reg_req_in.wdata[STAT_PUMP_UV_BIT]
		&& stat_q[STAT_PUMP_UV_BIT] |=> stat_q[STAT_PUMP_UV_BIT])
		else $error("Undervoltage flag lost on write zero.");
	chk_hot_noclear: assert property (over_temp_in && stat_q[STAT_DRV_ERR_BIT]
		|=> stat_q[STAT_DRV_ERR_BIT])
		else $error("Driver error cleared while hot.");
	chk_uv_disable: assert property (uv_s |=> !driver_enable_out && stat_q[STAT_PUMP_UV_BIT])
		else $error("Driver enabled during undervoltage.");
	chk_count_step: assert property (reg_req_in.wr && uart_mode_in && write_ok_in
		|=> count_q == $past(count_q) + 8'h01)
		else $error("Counter did not advance on UART write.");
	chk_count_spi: assert property (!uart_mode_in |=> count_q == $past(count_q))
		else $error("Counter moved in SPI operation.");
	chk_halt_steps: assert property (cfg_q.stop_enable && halt_s
		|=> !step_enable_out && standstill_out)
		else $error("Steps allowed during emergency stop.");
	chk_diag_a_drive: assert property (!cfg_q.diag_a_drive_select && diag_a_event_in
		|=> diag_a_pin_out.enable && !diag_a_pin_out.value)
		else $error("Diag A open-collector drive wrong.");
	chk_diag_b_drive: assert property (cfg_q.diag_b_drive_select
		|=> diag_b_pin_out.enable && diag_b_pin_out.value == $past(diag_b_event_in))
		else $error("Diag B push-pull drive wrong.");
	chk_hyst_sel: assert property (cfg_q.small_hysteresis |=> hyst_amount_out
		== ($past(freq_threshold_in) >> 5))
		else $error("Small hysteresis not applied.");
	chk_test_route: assert property (cfg_q.test_mode |=> test_out_enable_out
		&& test_select_out == $past(hold_current_setting_in[1:0]))
		else $error("Test output not routed.");

endmodule

`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module host_model (
	input wire logic sys_clk_in,
	input wire logic [31:0] rdata_in,
	output cfg_status_pkg::reg_req_t req_out
);
	import cfg_status_pkg::*;

	initial begin
		req_out = '0;
	end

	// Issues one write or read, then releases the bus with both strobes low and address and data inverted.
	task automatic put(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		req_out <= '{w, ~w, a, d};
		@(posedge sys_clk_in);
		req_out <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	task automatic get(input logic [6:0] a, output logic [31:0] d);
		put(1'b0, a, 32'h0);
		#1 d = rdata_in;
	endtask
endmodule

`default_nettype wire

// [tb/global_config_status_bank_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module global_config_status_bank_tb_top;
	import cfg_status_pkg::*;

	typedef struct packed {
		logic [31:0] cfg;
		logic [4:0] hold;
		logic [1:0] ev;
		logic [19:0] freq;
		logic [3:0] diag;
		logic [19:0] hyst;
		logic [2:0] test;
	} row_t;

	logic clk = 1'b0, rst_n = 1'b0, uart = 1'b0, wok = 1'b1, halt = 1'b0, uv = 1'b0;
	logic drv = 1'b0, ot = 1'b0, ev_a = 1'b0, ev_b = 1'b0;
	logic [4:0] hold = 5'h00;
	logic [19:0] freq = 20'h00000;
	logic [31:0] rdata, rd;
	reg_req_t req;
	pin_drive_t da, db;
	logic [19:0] hyst;
	logic step, stand, den, dm, qv, te;
	logic [1:0] ts;
	coil_t coil;
	int miscompares = 0, comparisons = 0;
	row_t rows [4] = '{
		'{32'h00000000, 5'h00, 2'b10, 20'h12340, 4'b0100, 20'h01234, 3'h0},
		'{32'h00003000, 5'h00, 2'b01, 20'hfffff, 4'b0111, 20'h0ffff, 3'h0},
		'{32'h00004000, 5'h00, 2'b11, 20'hfffff, 4'b0101, 20'h07fff, 3'h0},
		'{32'h00020fff, 5'h1e, 2'b00, 20'h00010, 4'b0000, 20'h00001, 3'h6}};

	always #50 clk = ~clk;

	host_model i_host (.sys_clk_in(clk), .rdata_in(rdata), .req_out(req));

	global_config_status_bank i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_req_in(req),
		.uart_mode_in(uart), .write_ok_in(wok), .halt_request_input_in(halt),
		.pump_undervoltage_in(uv), .drv_shutdown_in(drv), .over_temp_in(ot),
		.diag_a_event_in(ev_a), .diag_b_event_in(ev_b), .hold_current_setting_in(hold),
		.freq_threshold_in(freq), .reg_rdata_out(rdata), .diag_a_pin_out(da),
		.diag_b_pin_out(db), .hyst_amount_out(hyst), .step_enable_out(step),
		.standstill_out(stand), .driver_enable_out(den), .direct_mode_out(dm),
		.quiet_velocity_reg_enable_out(qv), .coil_current_out(coil),
		.test_out_enable_out(te), .test_select_out(ts));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic rd_chk(input string name, input logic [6:0] a, input logic [31:0] exp);
		i_host.get(a, rd);
		check(name, rd, exp);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic reset_dut();
		@(posedge clk);
		rst_n <= 1'b0;
		wait_n(16);
		check("reset pins", {da, db, step}, 5'b01001);
		@(posedge clk);
		rst_n <= 1'b1;
		rd_chk("reset status", ADDR_GLOBAL_STATUS, 32'h1);
		rd_chk("reset config", ADDR_GLOBAL_CONFIG, 32'h0);
		rd_chk("reset count", ADDR_UART_WRITE_COUNTER, 32'h0);
	endtask

	initial begin
		#2000000;
		miscompares++;
		stop_test();
	end

	initial begin
		reset_dut();
		foreach (rows[i]) begin
			@(posedge clk);
			hold <= rows[i].hold;
			{ev_a, ev_b} <= rows[i].ev;
			freq <= rows[i].freq;
			i_host.put(1'b1, ADDR_GLOBAL_CONFIG, rows[i].cfg);
			rd_chk("config", ADDR_GLOBAL_CONFIG, rows[i].cfg & 32'h0003f000);
			check("diag", {da, db}, rows[i].diag);
			check("hyst", hyst, rows[i].hyst);
			check("test", {te, ts}, rows[i].test);
		end
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h1);
		rd_chk("status w1c", ADDR_GLOBAL_STATUS, 32'h0);
		@(posedge clk);
		{drv, ot} <= 2'b11;
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h0);
		drv <= 1'b0;
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h2);
		rd_chk("hot clear", ADDR_GLOBAL_STATUS, 32'h2);
		check("drv off", den, 1'b0);
		@(posedge clk);
		{drv, ot} <= 2'b10;
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h2);
		drv <= 1'b0;
		rd_chk("set wins", ADDR_GLOBAL_STATUS, 32'h2);
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h2);
		rd_chk("cool clear", ADDR_GLOBAL_STATUS, 32'h0);
		@(posedge clk);
		uv <= 1'b1;
		wait_n(5);
		check("uv drv", den, 1'b0);
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h4);
		rd_chk("uv latch", ADDR_GLOBAL_STATUS, 32'h4);
		@(posedge clk);
		uv <= 1'b0;
		wait_n(5);
		check("drv on", den, 1'b1);
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h3);
		rd_chk("w0 keeps", ADDR_GLOBAL_STATUS, 32'h4);
		i_host.put(1'b1, ADDR_GLOBAL_STATUS, 32'h4);
		rd_chk("uv clear", ADDR_GLOBAL_STATUS, 32'h0);
		@(posedge clk);
		halt <= 1'b1;
		wait_n(5);
		check("no stop", {step, stand}, 2'b10);
		i_host.put(1'b1, ADDR_GLOBAL_CONFIG, 32'h8000);
		wait_n(2);
		check("stop", {step, stand}, 2'b01);
		@(posedge clk);
		hold <= 5'h0f;
		i_host.put(1'b1, ADDR_TARGET_POSITION, 32'h006401c0);
		wait_n(2);
		check("coil off", coil, 18'h0);
		i_host.put(1'b1, ADDR_GLOBAL_CONFIG, 32'h10000);
		wait_n(2);
		check("coil", coil, {9'h1e0, 9'h032});
		check("modes", {dm, qv, step}, 3'b101);
		@(posedge clk);
		uart <= 1'b1;
		repeat (3) i_host.put(1'b1, 7'h7f, 32'h0);
		rd_chk("count", ADDR_UART_WRITE_COUNTER, 32'h3);
		rd_chk("count reread", ADDR_UART_WRITE_COUNTER, 32'h3);
		rd_chk("unmapped", 7'h7f, 32'h0);
		@(posedge clk);
		wok <= 1'b0;
		i_host.put(1'b1, ADDR_UART_WRITE_COUNTER, 32'h55);
		wok <= 1'b1;
		rd_chk("bad crc", ADDR_UART_WRITE_COUNTER, 32'h3);
		repeat (252) i_host.put(1'b1, ADDR_UART_WRITE_COUNTER, 32'h55);
		rd_chk("count top", ADDR_UART_WRITE_COUNTER, 32'hff);
		i_host.put(1'b1, 7'h7f, 32'h0);
		rd_chk("count wrap", ADDR_UART_WRITE_COUNTER, 32'h0);
		reset_dut();
		stop_test();
	end
endmodule

`default_nettype wire
